/* File: hdl/avbsp_pkg.sv */
// Shared constants and types for the bridging byte stream port.
package avbsp_pkg;
   // ************************************************************
   // Widths and reset values
   // ************************************************************
   localparam int unsigned BYTE_W = 8;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic CE_RST = 1'b0;
   localparam logic TOGGLE_RST = 1'b0;
   localparam logic [1:0] SYNC_RST = 2'h0;
   localparam logic [2:0] EVT_SYNC_RST = 3'h0;

   // ************************************************************
   // Transmit sequencer states, Gray coded along idle-wait-run
   // ************************************************************
   typedef enum logic [1:0] {
      AVBSP_TX_IDLE = 2'h0,
      AVBSP_TX_WAIT = 2'h1,
      AVBSP_TX_RUN = 2'h3,
      AVBSP_TX_DRAIN = 2'h2
   } avbsp_tx_state_t;
endpackage

/* File: hdl/avbsp_port.sv */
// Bridging byte stream port of the MAC with transmit and receive multiplexing.
`timescale 1ns/100ps
// How it works
// - Bridging ports only work when the build parameter is one.
// - Each stream moves one byte per beat over eight data bits, no strobes.
// - The port sources stream clocks and enables from its own MAC clock.
// - Transmit stream clock is the MAC clock, 125 MHz or 25 MHz by speed.
// - Transmit ready follows the enable: every cycle at gigabit, alternate at 100M.
// - Transmit ready rises when the port can take a bridging frame.
// - After the first byte ready stays low until the MAC starts sending.
// - The transmit error flag exists but is unconnected and has no effect.
// - Receive clock is the MAC clock; receive valid is the receive enable.
// - Receive valid high means a new byte on the receive data.
// - After the penultimate byte receive valid stays low until good or bad.
// - Good or bad report releases the final byte with last for one beat.
// - Frame bad flag is high on the final beat for bad, low for good.
// - Every filtered frame, good or bad, is forwarded to the stream.
// - Bridging and legacy frames share the MAC by priority and time slots.
module avbsp_port #(
   parameter bit bridging_build_enable = 1'b1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cfg_speed_gigabit,
   input wire logic cfg_bridge_run,
   output logic evt_tx_frame_sent,
   output logic evt_rx_frame_good,
   output logic evt_rx_frame_bad,
   input wire logic mac_clk,
   output logic bridge_tx_stream_clock,
   output logic bridge_tx_stream_ready,
   input wire logic bridge_tx_stream_valid,
   input wire logic [7:0] bridge_tx_stream_byte,
   input wire logic bridge_tx_stream_last,
   input wire logic bridge_tx_stream_error,
   output logic bridge_rx_stream_clock,
   output logic bridge_rx_stream_valid,
   output logic [7:0] bridge_rx_stream_byte,
   output logic bridge_rx_stream_last,
   output logic bridge_rx_frame_bad,
   input wire logic legacy_tx_valid,
   input wire logic [7:0] legacy_tx_byte,
   input wire logic legacy_tx_last,
   output logic legacy_tx_ready,
   output logic legacy_rx_valid,
   output logic [7:0] legacy_rx_byte,
   output logic legacy_rx_last,
   output logic legacy_rx_bad,
   output logic mac_tx_request,
   output logic [7:0] mac_tx_byte,
   output logic mac_tx_last,
   output logic mac_tx_enable,
   input wire logic mac_tx_started,
   input wire logic mac_rx_valid,
   input wire logic [7:0] mac_rx_byte,
   input wire logic mac_rx_is_bridging,
   input wire logic mac_rx_good,
   input wire logic mac_rx_bad
);
   // ************************************************************
   // Configuration crossing into the MAC clock domain
   // ************************************************************
   logic [1:0] speed_sync_q;
   logic [1:0] run_sync_q;
   logic gig;
   logic run;

   always_ff @(posedge mac_clk or negedge rst_n) begin
      if (!rst_n) begin
         speed_sync_q <= avbsp_pkg::SYNC_RST;
         run_sync_q <= avbsp_pkg::SYNC_RST;
      end else begin
         speed_sync_q <= {speed_sync_q[0], cfg_speed_gigabit};
         run_sync_q <= {run_sync_q[0], cfg_bridge_run};
      end
   end

   assign gig = speed_sync_q[1];
   // A build without bridging never arms the bridging path.
   assign run = run_sync_q[1] & bridging_build_enable;

   // Stream clocks are the MAC clock itself, forwarded rather than re-timed.
   assign bridge_tx_stream_clock = mac_clk;
   assign bridge_rx_stream_clock = mac_clk;

   // ************************************************************
   // MAC clock enable
   // ************************************************************
   logic ce_q;
   logic ce_d;

   assign ce_d = gig | ~ce_q;

   always_ff @(posedge mac_clk or negedge rst_n) begin
      if (!rst_n) begin
         ce_q <= avbsp_pkg::CE_RST;
      end else begin
         ce_q <= ce_d;
      end
   end

   // ************************************************************
   // Transmit sequencer and multiplexer
   // ************************************************************
   avbsp_pkg::avbsp_tx_state_t tx_state_q;
   avbsp_pkg::avbsp_tx_state_t tx_state_d;
   logic src_legacy_q;
   logic src_legacy_d;
   logic turn_legacy_q;
   logic br_take;
   logic lg_take;
   logic take_last;
   logic [7:0] take_byte;
   logic br_ready_d;
   logic lg_ready_d;

   assign br_take = bridge_tx_stream_ready & bridge_tx_stream_valid;
   assign lg_take = legacy_tx_ready & legacy_tx_valid;
   assign take_last = src_legacy_q ? legacy_tx_last : bridge_tx_stream_last;
   assign take_byte = src_legacy_q ? legacy_tx_byte : bridge_tx_stream_byte;

   always_comb begin
      tx_state_d = tx_state_q;
      src_legacy_d = src_legacy_q;
      case (tx_state_q)
         avbsp_pkg::AVBSP_TX_IDLE: begin
            // A take fixes the source of the slot, so arbitration cannot swap it on the same beat.
            if (br_take) begin
               src_legacy_d = 1'b0;
               tx_state_d = avbsp_pkg::AVBSP_TX_WAIT;
            end else if (lg_take) begin
               src_legacy_d = 1'b1;
               tx_state_d = avbsp_pkg::AVBSP_TX_WAIT;
            end else if (run && bridge_tx_stream_valid && !(turn_legacy_q && legacy_tx_valid)) begin
               // Bridging wins unless the previous slot went to it and legacy waits.
               src_legacy_d = 1'b0;
            end else if (legacy_tx_valid) begin
               src_legacy_d = 1'b1;
            end
         end
         avbsp_pkg::AVBSP_TX_WAIT: begin
            if (mac_tx_last) begin
               tx_state_d = avbsp_pkg::AVBSP_TX_DRAIN;
            end else if (mac_tx_started) begin
               tx_state_d = avbsp_pkg::AVBSP_TX_RUN;
            end
         end
         avbsp_pkg::AVBSP_TX_RUN: begin
            if ((br_take || lg_take) && take_last) begin
               tx_state_d = avbsp_pkg::AVBSP_TX_DRAIN;
            end
         end
         avbsp_pkg::AVBSP_TX_DRAIN: begin
            // One-byte frames still wait for the MAC to start before the slot ends.
            if (mac_tx_started || !mac_tx_request) begin
               tx_state_d = avbsp_pkg::AVBSP_TX_IDLE;
            end
         end
         default: begin
            tx_state_d = avbsp_pkg::AVBSP_TX_IDLE;
         end
      endcase
   end

   always_comb begin
      br_ready_d = 1'b0;
      lg_ready_d = 1'b0;
      case (tx_state_d)
         avbsp_pkg::AVBSP_TX_IDLE: begin
            br_ready_d = ce_d & run & ~src_legacy_d;
            lg_ready_d = ce_d & src_legacy_d;
         end
         avbsp_pkg::AVBSP_TX_RUN: begin
            br_ready_d = ce_d & ~src_legacy_d;
            lg_ready_d = ce_d & src_legacy_d;
         end
         default: begin
            br_ready_d = 1'b0;
            lg_ready_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mac_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_q <= avbsp_pkg::AVBSP_TX_IDLE;
         src_legacy_q <= 1'b0;
         turn_legacy_q <= 1'b0;
         bridge_tx_stream_ready <= 1'b0;
         legacy_tx_ready <= 1'b0;
      end else begin
         tx_state_q <= tx_state_d;
         src_legacy_q <= src_legacy_d;
         bridge_tx_stream_ready <= br_ready_d;
         legacy_tx_ready <= lg_ready_d;
         if (tx_state_q == avbsp_pkg::AVBSP_TX_WAIT) begin
            turn_legacy_q <= ~src_legacy_q;
         end
      end
   end

   // The error flag is accepted on the port but deliberately left unused.
   logic unused_tx_error;
   assign unused_tx_error = bridge_tx_stream_error;

   always_ff @(posedge mac_clk or negedge rst_n) begin
      if (!rst_n) begin
         mac_tx_request <= 1'b0;
         mac_tx_byte <= avbsp_pkg::BYTE_RST;
         mac_tx_last <= 1'b0;
         mac_tx_enable <= avbsp_pkg::CE_RST;
      end else begin
         mac_tx_enable <= ce_d;
         if (br_take || lg_take) begin
            mac_tx_byte <= take_byte;
            mac_tx_last <= take_last;
         end
         if ((br_take || lg_take) && tx_state_q == avbsp_pkg::AVBSP_TX_IDLE) begin
            mac_tx_request <= 1'b1;
         end else if (mac_tx_started) begin
            mac_tx_request <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Receive demultiplexer with last-byte hold
   // ************************************************************
   logic rx_in_frame_q;
   logic rx_bridging_q;
   logic rx_held_q;
   logic [7:0] rx_hold_q;
   logic rx_cls;
   logic rx_end;
   logic rx_push;
   logic rx_fin;

   // Classification is taken on the first byte and kept for the frame.
   assign rx_cls = rx_in_frame_q ? rx_bridging_q : (mac_rx_is_bridging & run);
   assign rx_end = mac_rx_good | mac_rx_bad;
   assign rx_push = mac_rx_valid & rx_held_q;
   assign rx_fin = rx_end & rx_held_q;

   always_ff @(posedge mac_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_in_frame_q <= 1'b0;
         rx_bridging_q <= 1'b0;
         rx_held_q <= 1'b0;
         rx_hold_q <= avbsp_pkg::BYTE_RST;
      end else begin
         if (mac_rx_valid) begin
            rx_hold_q <= mac_rx_byte;
            rx_held_q <= 1'b1;
            rx_in_frame_q <= 1'b1;
            rx_bridging_q <= rx_cls;
         end else if (rx_end) begin
            rx_held_q <= 1'b0;
            rx_in_frame_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mac_clk or negedge rst_n) begin
      if (!rst_n) begin
         bridge_rx_stream_valid <= 1'b0;
         bridge_rx_stream_byte <= avbsp_pkg::BYTE_RST;
         bridge_rx_stream_last <= 1'b0;
         bridge_rx_frame_bad <= 1'b0;
         legacy_rx_valid <= 1'b0;
         legacy_rx_byte <= avbsp_pkg::BYTE_RST;
         legacy_rx_last <= 1'b0;
         legacy_rx_bad <= 1'b0;
      end else begin
         // The newest byte is always held back, so valid drops after the penultimate one.
         bridge_rx_stream_valid <= (rx_push | rx_fin) & rx_bridging_q;
         legacy_rx_valid <= (rx_push | rx_fin) & ~rx_bridging_q;
         bridge_rx_stream_last <= rx_fin & ~rx_push & rx_bridging_q;
         bridge_rx_frame_bad <= rx_fin & ~rx_push & mac_rx_bad & rx_bridging_q;
         legacy_rx_last <= rx_fin & ~rx_push & ~rx_bridging_q;
         legacy_rx_bad <= rx_fin & ~rx_push & mac_rx_bad & ~rx_bridging_q;
         if (rx_push | rx_fin) begin
            bridge_rx_stream_byte <= rx_hold_q;
            legacy_rx_byte <= rx_hold_q;
         end
      end
   end

   // ************************************************************
   // Event toggles back to the system clock domain
   // ************************************************************
   logic [2:0] evt_tgl_q;
   logic [2:0] evt_sent;

   assign evt_sent[0] = (br_take | lg_take) & take_last & ~src_legacy_q;
   assign evt_sent[1] = rx_fin & ~rx_push & rx_bridging_q & ~mac_rx_bad;
   assign evt_sent[2] = rx_fin & ~rx_push & rx_bridging_q & mac_rx_bad;

   always_ff @(posedge mac_clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_tgl_q <= avbsp_pkg::EVT_SYNC_RST;
      end else begin
         evt_tgl_q <= evt_tgl_q ^ evt_sent;
      end
   end

   logic [2:0] evt_s1_q;
   logic [2:0] evt_s2_q;
   logic [2:0] evt_s3_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         evt_s1_q <= avbsp_pkg::EVT_SYNC_RST;
         evt_s2_q <= avbsp_pkg::EVT_SYNC_RST;
         evt_s3_q <= avbsp_pkg::EVT_SYNC_RST;
         evt_tx_frame_sent <= 1'b0;
         evt_rx_frame_good <= 1'b0;
         evt_rx_frame_bad <= 1'b0;
      end else begin
         evt_s1_q <= evt_tgl_q;
         evt_s2_q <= evt_s1_q;
         evt_s3_q <= evt_s2_q;
         evt_tx_frame_sent <= evt_s2_q[0] ^ evt_s3_q[0];
         evt_rx_frame_good <= evt_s2_q[1] ^ evt_s3_q[1];
         evt_rx_frame_bad <= evt_s2_q[2] ^ evt_s3_q[2];
      end
   end
endmodule

/* File: test/avbsp_ext_src.sv */
// Model of the outside packetising logic feeding the bridging transmit stream.
`timescale 1ns/100ps
module avbsp_ext_src (
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] len,
   input wire logic [7:0] base,
   input wire logic ready,
   output logic valid,
   output logic [7:0] data,
   output logic last
);
   logic valid_q = 1'b0;
   logic last_q = 1'b0;
   logic [7:0] data_q = 8'h00;
   logic [7:0] idx_q = 8'h01;
   assign valid = valid_q;
   assign last = last_q;
   assign data = data_q;
   // While valid, the source moves on only on a beat with ready high, so ready holds it back.
   always @(posedge clk) begin
      if (valid_q && ready && !last_q) begin
         data_q <= base + idx_q;
         last_q <= (idx_q == len - 8'h01);
         idx_q <= idx_q + 8'h01;
      end else if (ready || !valid_q) begin
         valid_q <= go;
         data_q <= go ? base : ~data_q;
         last_q <= 1'b0;
         idx_q <= 8'h01;
      end
   end
endmodule

/* File: test/avbsp_port_asserts.sv */
// Assertions on the bridging byte stream port, bound to every instance.
`timescale 1ns/100ps
module avbsp_port_asserts (
   input logic mac_clk,
   input logic rst_n,
   input logic cfg_speed_gigabit,
   input logic cfg_bridge_run,
   input logic bridge_tx_stream_ready,
   input logic bridge_tx_stream_valid,
   input logic bridge_tx_stream_last,
   input logic mac_tx_request,
   input logic mac_tx_enable,
   input logic mac_tx_started,
   input logic bridge_rx_stream_valid,
   input logic bridge_rx_stream_last,
   input logic bridge_rx_frame_bad,
   input logic mac_rx_valid,
   input logic mac_rx_is_bridging,
   input logic mac_rx_good,
   input logic mac_rx_bad
);
   logic tx_frm_q;
   logic rx_brg_q;
   logic hs;
   assign hs = bridge_tx_stream_ready && bridge_tx_stream_valid;
   default clocking @(posedge mac_clk); endclocking
   default disable iff (!rst_n);
   // Frame trackers, so that a frame in flight is known from the cycle after its first beat.
   always_ff @(posedge mac_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_frm_q <= 1'b0;
         rx_brg_q <= 1'b0;
      end else begin
         if (hs) tx_frm_q <= !bridge_tx_stream_last;
         if (mac_rx_good || mac_rx_bad) rx_brg_q <= 1'b0;
         else if (mac_rx_valid && mac_rx_is_bridging && cfg_bridge_run) rx_brg_q <= 1'b1;
      end
   end
   a_tx_first_wait: assert property (
      hs && !tx_frm_q |=> !bridge_tx_stream_ready && mac_tx_request) else $error("no wait after first byte");
   a_tx_hold_low: assert property (
      tx_frm_q && mac_tx_request && !mac_tx_started && !$past(mac_tx_started) |-> !bridge_tx_stream_ready)
      else $error("ready before start");
   a_tx_gig_run: assert property (
      cfg_speed_gigabit [*8] ##0 (tx_frm_q && hs && !bridge_tx_stream_last) |=> bridge_tx_stream_ready)
      else $error("gigabit ready gap");
   a_tx_half_alt: assert property (
      !cfg_speed_gigabit [*8] ##0 bridge_tx_stream_ready |=> !bridge_tx_stream_ready) else $error("100M ready twice");
   a_tx_ready_ce: assert property (bridge_tx_stream_ready |-> mac_tx_enable) else $error("ready off enable");
   a_tx_gig_ce: assert property (cfg_speed_gigabit [*8] |-> mac_tx_enable) else $error("gigabit enable gap");
   a_rx_last_beat: assert property (
      bridge_rx_stream_last || bridge_rx_frame_bad |-> bridge_rx_stream_valid && bridge_rx_stream_last)
      else $error("stray last or bad");
   a_rx_good_end: assert property (
      rx_brg_q && mac_rx_good |=> bridge_rx_stream_valid && bridge_rx_stream_last && !bridge_rx_frame_bad)
      else $error("good end wrong");
   a_rx_bad_end: assert property (
      rx_brg_q && mac_rx_bad |=> bridge_rx_stream_valid && bridge_rx_stream_last && bridge_rx_frame_bad)
      else $error("bad end wrong");
   a_rx_gap_low: assert property (
      rx_brg_q && !mac_rx_valid && !mac_rx_good && !mac_rx_bad |=> !bridge_rx_stream_valid)
      else $error("rx beat in gap");
   c_tx_first: cover property (hs && !tx_frm_q);
   c_rx_good: cover property (rx_brg_q && mac_rx_good);
   c_rx_bad: cover property (rx_brg_q && mac_rx_bad);
endmodule
bind avbsp_port avbsp_port_asserts u_chk (.*);

/* File: test/testbench.sv */
// Self-checking bench for the bridging byte stream port.
`timescale 1ns/100ps
module testbench;
   logic mclk = 1'b0, mac_clk = 1'b0, rst_n = 1'b0, tx_go = 1'b0, last_hs_q = 1'b0;
   logic [7:0] tx_len = 8'h03, tx_base = 8'h00;
   logic cfg_speed_gigabit = 1'b1, cfg_bridge_run = 1'b1, evt_tx_frame_sent, evt_rx_frame_good, evt_rx_frame_bad;
   logic bridge_tx_stream_clock, bridge_tx_stream_ready, bridge_tx_stream_valid, bridge_tx_stream_last;
   logic bridge_tx_stream_error = 1'b0, bridge_rx_stream_clock, bridge_rx_stream_valid, bridge_rx_stream_last;
   logic bridge_rx_frame_bad, legacy_tx_valid = 1'b0, legacy_tx_last = 1'b0, legacy_tx_ready, legacy_rx_valid;
   logic legacy_rx_last, legacy_rx_bad, mac_tx_request, mac_tx_last, mac_tx_enable, mac_tx_started = 1'b0;
   logic mac_rx_valid = 1'b0, mac_rx_is_bridging = 1'b0, mac_rx_good = 1'b0, mac_rx_bad = 1'b0;
   logic [7:0] bridge_tx_stream_byte, bridge_rx_stream_byte, legacy_tx_byte = 8'h00, legacy_rx_byte, mac_tx_byte;
   logic [7:0] mac_rx_byte = 8'h00;
   logic [9:0] exp_q[$];
   int fail_count = 0, compares = 0, cyc = 0, n_bad = 0, bad_sent = 0, tx_done = 0, seed = 32'h6459;
   int n_sent = 0, n_good = 0, good_sent = 0, n_lrx = 0, exp_lrx = 0;
   avbsp_port #(.bridging_build_enable(1'b1)) uut (.*);
   avbsp_ext_src u_src (.clk(mac_clk), .go(tx_go), .len(tx_len), .base(tx_base), .ready(bridge_tx_stream_ready),
      .valid(bridge_tx_stream_valid), .data(bridge_tx_stream_byte), .last(bridge_tx_stream_last));
   always #5 mclk = ~mclk;
   initial begin
      #3.7;
      forever #15 mac_clk = ~mac_clk;
   end
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge mclk) begin
      n_bad += evt_rx_frame_bad;
      n_sent += evt_tx_frame_sent;
      n_good += evt_rx_frame_good;
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         summarize();
      end
   end
   // The MAC starts after a random delay, and the error flag toggles at random while it must be ignored.
   always @(negedge mac_clk) begin
      mac_tx_started <= mac_tx_request && ($random(seed) % 4 == 0);
      bridge_tx_stream_error <= ($random(seed) % 3 == 0);
   end
   always @(posedge mac_clk) begin
      if (last_hs_q) check({1'b0, mac_tx_last, mac_tx_byte}, {2'b01, tx_base + tx_len - 8'h01});
      last_hs_q <= bridge_tx_stream_valid && bridge_tx_stream_ready && bridge_tx_stream_last;
      tx_done += (bridge_tx_stream_valid && bridge_tx_stream_ready && bridge_tx_stream_last);
      n_lrx += (rst_n && legacy_rx_valid);
      if (rst_n && bridge_rx_stream_valid)
         check({bridge_rx_stream_last, bridge_rx_frame_bad, bridge_rx_stream_byte},
            exp_q.size() > 0 ? exp_q.pop_front() : ~{bridge_rx_stream_last, bridge_rx_frame_bad, bridge_rx_stream_byte});
   end
   task automatic tx_pair(input logic [7:0] n);
      int d0;
      d0 = tx_done;
      @(negedge mac_clk);
      {tx_len, tx_base, tx_go} = {n, 8'($random(seed)), 1'b1};
      for (int t = 0; t < 4000 && tx_done < d0 + 2; t++) begin
         @(negedge mac_clk);
         if (tx_done == d0 + 1) tx_go = 1'b0;
      end
      check(10'(tx_done - d0), 10'h002);
   endtask
   task automatic leg_tx;
      int t;
      @(negedge mac_clk);
      {legacy_tx_valid, legacy_tx_byte, legacy_tx_last} = {1'b1, 8'($random(seed)), 1'b1};
      t = 0;
      do begin
         @(posedge mac_clk);
         t++;
      end while (legacy_tx_ready !== 1'b1 && t < 4000);
      check(10'(t < 4000), 10'h001);
      @(negedge mac_clk);
      {legacy_tx_valid, legacy_tx_byte} = {1'b0, ~legacy_tx_byte};
   endtask
   task automatic rx_frame(input logic brg, input int n, input logic bad);
      logic [7:0] b;
      for (int i = 0; i < n; i++) begin
         @(negedge mac_clk);
         b = 8'($random(seed));
         {mac_rx_valid, mac_rx_byte, mac_rx_is_bridging} = {1'b1, b, brg};
         if (brg && cfg_bridge_run) exp_q.push_back({i == n - 1, (i == n - 1) && bad, b});
         if (!cfg_speed_gigabit) @(negedge mac_clk) mac_rx_valid = 1'b0;
      end
      @(negedge mac_clk) mac_rx_valid = 1'b0;
      repeat (3) @(negedge mac_clk);
      {mac_rx_good, mac_rx_bad} = {!bad, bad};
      @(negedge mac_clk) {mac_rx_good, mac_rx_bad} = 2'b00;
      bad_sent += (brg && cfg_bridge_run && bad);
      good_sent += (brg && cfg_bridge_run && !bad);
      exp_lrx += (brg && cfg_bridge_run) ? 0 : n;
   endtask
   initial begin
      int hi;
      hi = 0;
      repeat (12) @(posedge mclk);
      @(negedge mclk) rst_n = 1'b1;
      for (int s = 1; s >= 0; s--) begin
         @(negedge mclk) cfg_speed_gigabit = s[0];
         repeat (10) @(negedge mac_clk);
         fork
            tx_pair(8'h05);
            leg_tx();
         join
         tx_pair(8'h03);
         rx_frame(1'b1, 5, 1'b0);
         rx_frame(1'b1, 2, 1'b1);
         rx_frame(1'b0, 4, 1'b0);
      end
      @(negedge mclk) cfg_bridge_run = 1'b0;
      repeat (10) @(negedge mac_clk);
      for (int i = 0; i < 20; i++) @(negedge mac_clk) hi |= bridge_tx_stream_ready;
      check(10'(hi), 10'h000);
      rx_frame(1'b1, 3, 1'b0);
      repeat (20) @(negedge mac_clk);
      check(10'(n_bad), 10'(bad_sent));
      check(10'(n_good), 10'(good_sent));
      check(10'(n_sent), 10'h008);
      check(10'(n_lrx), 10'(exp_lrx));
      check(10'(exp_q.size()), 10'h000);
      summarize();
   end
endmodule
